// ### hw/bstd_pkg.sv
// Package of constants and types for the boundary-scan tap decoder.
// Assumes a single test access port per device and a ten-bit instruction register.
// Functional notes
// - Standard sixteen-state scan controller and operations.
// - Code 005 selects sample and preload.
// - Code 00F drives pins, captures inputs.
// - All-ones code selects one-bit bypass.
// - Code 007 selects 32-bit user code.
// - Unconfigured user code reads all ones.
// - Code 006 selects identification register.
// - Code 00B bypasses and tri-states all pins.
package bstd_pkg;
	// Instruction register width and codes.
	localparam int IR_W = 10;
	localparam logic [9:0] IR_SAMPLE = 10'h005;
	localparam logic [9:0] IR_EXTEST = 10'h00F;
	localparam logic [9:0] IR_BYPASS = 10'h3FF;
	localparam logic [9:0] IR_USERCODE = 10'h007;
	localparam logic [9:0] IR_IDCODE = 10'h006;
	localparam logic [9:0] IR_HIGHZ = 10'h00B;
	// Fixed capture pattern of the instruction register, low two bits 01.
	localparam logic [9:0] IR_CAPTURE = 10'h001;
	// Width of the user code and identification registers.
	localparam int CODE_W = 32;
	// User code value when nothing was configured.
	localparam logic [31:0] USERCODE_RST = 32'hFFFFFFFF;
	// Identification value; arbitrary neutral value, bit 0 set as required.
	localparam logic [31:0] IDCODE_DEF = 32'h0000_1001;

	// Controller states.
	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
		ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR,
		ST_EX2_IR, ST_UPD_IR
	} bstd_state_e;

	// Data register selection.
	typedef enum logic [2:0] {SEL_BYPASS, SEL_BOUNDARY, SEL_USER, SEL_ID} bstd_sel_e;
endpackage : bstd_pkg

// ### hw/bstd_pin_if.sv
`timescale 1ns/1ps
// Interface carrying boundary cells' pin-side signals between the tap and the pin block.
// Assumes both ends run on the core clock.
interface bstd_pin_if #(parameter int NPINS = 8);
	logic [NPINS-1:0] upd_val;   // Update latches, synchronised to the core clock.
	logic extest;                // Extest instruction active, synchronised.
	logic highz;                 // Highz instruction active, synchronised.
	logic [NPINS-1:0] pin_in;    // Captured pin levels, core clock.
	modport tap (output upd_val, output extest, output highz, input pin_in);
	modport pins (input upd_val, input extest, input highz, output pin_in);
endinterface : bstd_pin_if

// ### hw/bstd_pin_mux.sv
`timescale 1ns/1ps
// Pin block: chooses between core and boundary data on each user pin.
// Assumes pin inputs come from outside and need two flip-flops.
module bstd_pin_mux
	import bstd_pkg::*;
#(
	parameter int NPINS = 8
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	bstd_pin_if.pins pif,
	// Core side.
	input wire logic [NPINS-1:0] core_out_i,
	input wire logic [NPINS-1:0] core_oe_i,
	// Pin side.
	input wire logic [NPINS-1:0] pad_in_i,
	output logic [NPINS-1:0] pad_out_o,
	output logic [NPINS-1:0] pad_oe_o
);
	logic [NPINS-1:0] pad_s1_r; // First synchroniser stage.
	logic [NPINS-1:0] pad_s2_r; // Second synchroniser stage.
	wire [NPINS-1:0] out_nxt;
	wire [NPINS-1:0] oe_nxt;

	// Extest drives update values; highz releases every pin.
	assign out_nxt = pif.extest ? pif.upd_val : core_out_i;
	assign oe_nxt = pif.highz ? '0 : (pif.extest ? '1 : core_oe_i);

	// Registers pin outputs and synchronises pin inputs.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pad_s1_r <= '0;
			pad_s2_r <= '0;
			pad_out_o <= '0;
			pad_oe_o <= '0;
		end else if (ce_i) begin
			pad_s1_r <= pad_in_i;
			pad_s2_r <= pad_s1_r;
			pad_out_o <= out_nxt;
			pad_oe_o <= oe_nxt;
		end
	end

	assign pif.pin_in = pad_s2_r;
endmodule : bstd_pin_mux

// ### hw/bstd_tap.sv
`timescale 1ns/1ps
// Top of the boundary-scan tap decoder: controller, instruction and data registers.
// Assumes TCK comes from an external tester and is a clock domain of its own.
module bstd_tap
	import bstd_pkg::*;
#(
	parameter int NPINS = 8,
	parameter logic [31:0] USERCODE_VAL = USERCODE_RST,
	parameter logic [31:0] IDCODE_VAL = IDCODE_DEF
) (
	// Core clock and reset.
	input wire logic CORE_CLK_I,
	input wire logic RESET_N_I,
	input wire logic CLK_EN_I,
	// Scan link.
	input wire logic TCK_I,
	input wire logic TMS_I,
	input wire logic TDI_I,
	output logic TDO_O,
	output logic TDO_OE_O,
	// Core side of the user pins.
	input wire logic [NPINS-1:0] CORE_OUT_I,
	input wire logic [NPINS-1:0] CORE_OE_I,
	// User pins.
	input wire logic [NPINS-1:0] PAD_IN_I,
	output logic [NPINS-1:0] PAD_OUT_O,
	output logic [NPINS-1:0] PAD_OE_O
);
	// Boundary register: one capture/shift and one update cell per pin.
	localparam int BSR_W = NPINS;

	bstd_state_e state_r; // Controller state, TCK domain.
	bstd_state_e state_nxt;
	logic [IR_W-1:0] ir_sh_r;   // Instruction shift stage.
	logic [IR_W-1:0] ir_r;      // Active instruction.
	logic bypass_r;             // One-bit bypass cell.
	logic [CODE_W-1:0] dr32_r;  // Shared shifter for user code and identification.
	logic [BSR_W-1:0] bsr_r;    // Boundary shift cells.
	logic [BSR_W-1:0] bupd_r;   // Boundary update cells.
	logic tdo_r;                // Falling-edge output data.
	logic tdo_oe_r;             // Falling-edge output enable.
	logic tck_rst_n;            // Reset for the TCK domain.
	// Core-domain synchronisers for pin data and instruction flags.
	logic [BSR_W-1:0] upd_s1_r;
	logic [BSR_W-1:0] upd_s2_r;
	logic [1:0] mode_s1_r;
	logic [1:0] mode_s2_r;
	// Pin levels held in core domain, resampled into TCK domain on every rising TCK edge.
	logic [BSR_W-1:0] pin_t1_r;
	logic [BSR_W-1:0] pin_t2_r;

	bstd_pin_if #(.NPINS(NPINS)) pif ();

	assign tck_rst_n = RESET_N_I;

	// Decodes the instruction into a data register choice.
	function automatic bstd_sel_e dec_sel(input logic [IR_W-1:0] ir);
		bstd_sel_e s;
		s = SEL_BYPASS;
		if (ir == IR_SAMPLE || ir == IR_EXTEST) begin
			s = SEL_BOUNDARY;
		end else if (ir == IR_USERCODE) begin
			s = SEL_USER;
		end else if (ir == IR_IDCODE) begin
			s = SEL_ID;
		end
		return s;
	endfunction : dec_sel

	wire bstd_sel_e sel = dec_sel(ir_r);
	wire is_extest = (ir_r == IR_EXTEST);
	wire is_highz = (ir_r == IR_HIGHZ);
	wire shifting = (state_r == ST_SH_DR) || (state_r == ST_SH_IR);

	// Controller next-state table, standard sixteen states.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_RESET: state_nxt = TMS_I ? ST_RESET : ST_IDLE;
			ST_IDLE: state_nxt = TMS_I ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: state_nxt = TMS_I ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: state_nxt = TMS_I ? ST_EX1_DR : ST_SH_DR;
			ST_SH_DR: state_nxt = TMS_I ? ST_EX1_DR : ST_SH_DR;
			ST_EX1_DR: state_nxt = TMS_I ? ST_UPD_DR : ST_PAU_DR;
			ST_PAU_DR: state_nxt = TMS_I ? ST_EX2_DR : ST_PAU_DR;
			ST_EX2_DR: state_nxt = TMS_I ? ST_UPD_DR : ST_SH_DR;
			ST_UPD_DR: state_nxt = TMS_I ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: state_nxt = TMS_I ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: state_nxt = TMS_I ? ST_EX1_IR : ST_SH_IR;
			ST_SH_IR: state_nxt = TMS_I ? ST_EX1_IR : ST_SH_IR;
			ST_EX1_IR: state_nxt = TMS_I ? ST_UPD_IR : ST_PAU_IR;
			ST_PAU_IR: state_nxt = TMS_I ? ST_EX2_IR : ST_PAU_IR;
			ST_EX2_IR: state_nxt = TMS_I ? ST_UPD_IR : ST_SH_IR;
			ST_UPD_IR: state_nxt = TMS_I ? ST_SEL_DR : ST_IDLE;
			default: state_nxt = ST_RESET;
		endcase
	end

	// Controller state register; the reset state loads the identification code.
	always_ff @(posedge TCK_I or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			state_r <= ST_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Instruction register: capture, shift, update; reset selects identification.
	always_ff @(posedge TCK_I or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			ir_sh_r <= IR_CAPTURE;
			ir_r <= IR_IDCODE;
		end else if (state_r == ST_RESET) begin
			ir_r <= IR_IDCODE;
		end else if (state_r == ST_CAP_IR) begin
			ir_sh_r <= IR_CAPTURE;
		end else if (state_r == ST_SH_IR) begin
			ir_sh_r <= {TDI_I, ir_sh_r[IR_W-1:1]};
		end else if (state_r == ST_UPD_IR) begin
			ir_r <= ir_sh_r;
		end
	end

	// Bypass cell captures zero and shifts TDI in one clock.
	always_ff @(posedge TCK_I or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			bypass_r <= 1'b0;
		end else if (sel == SEL_BYPASS) begin
			if (state_r == ST_CAP_DR) begin
				bypass_r <= 1'b0;
			end else if (state_r == ST_SH_DR) begin
				bypass_r <= TDI_I;
			end
		end
	end

	// Shared 32-bit shifter loads user code or identification at capture.
	always_ff @(posedge TCK_I or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			dr32_r <= '0;
		end else if (sel == SEL_USER || sel == SEL_ID) begin
			if (state_r == ST_CAP_DR) begin
				dr32_r <= (sel == SEL_USER) ? USERCODE_VAL : IDCODE_VAL;
			end else if (state_r == ST_SH_DR) begin
				dr32_r <= {TDI_I, dr32_r[CODE_W-1:1]};
			end
		end
	end

	// Pin levels enter the TCK domain through two flip-flops.
	always_ff @(posedge TCK_I or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			pin_t1_r <= '0;
			pin_t2_r <= '0;
		end else begin
			pin_t1_r <= pif.pin_in;
			pin_t2_r <= pin_t1_r;
		end
	end

	// Boundary register captures pins, shifts, and updates on the update state.
	always_ff @(posedge TCK_I or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			bsr_r <= '0;
			bupd_r <= '0;
		end else if (sel == SEL_BOUNDARY) begin
			if (state_r == ST_CAP_DR) begin
				bsr_r <= pin_t2_r;
			end else if (state_r == ST_SH_DR) begin
				bsr_r <= {TDI_I, bsr_r[BSR_W-1:1]};
			end else if (state_r == ST_UPD_DR) begin
				bupd_r <= bsr_r;
			end
		end
	end

	// Serial output changes on the falling edge and floats outside shifting.
	always_ff @(negedge TCK_I or negedge tck_rst_n) begin
		if (!tck_rst_n) begin
			tdo_r <= 1'b0;
			tdo_oe_r <= 1'b0;
		end else begin
			tdo_oe_r <= shifting;
			if (state_r == ST_SH_IR) begin
				tdo_r <= ir_sh_r[0];
			end else if (sel == SEL_BOUNDARY) begin
				tdo_r <= bsr_r[0];
			end else if (sel == SEL_USER || sel == SEL_ID) begin
				tdo_r <= dr32_r[0];
			end else begin
				tdo_r <= bypass_r;
			end
		end
	end

	assign TDO_O = tdo_r;
	assign TDO_OE_O = tdo_oe_r;

	// Update values and instruction flags cross into the core clock domain.
	always_ff @(posedge CORE_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			upd_s1_r <= '0;
			upd_s2_r <= '0;
			mode_s1_r <= '0;
			mode_s2_r <= '0;
		end else if (CLK_EN_I) begin
			upd_s1_r <= bupd_r;
			upd_s2_r <= upd_s1_r;
			mode_s1_r <= {is_highz, is_extest};
			mode_s2_r <= mode_s1_r;
		end
	end

	assign pif.upd_val = upd_s2_r;
	assign pif.extest = mode_s2_r[0];
	assign pif.highz = mode_s2_r[1];

	// Pin block, core clock domain.
	bstd_pin_mux #(.NPINS(NPINS)) u_pins (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RESET_N_I),
		.ce_i(CLK_EN_I),
		.pif(pif.pins),
		.core_out_i(CORE_OUT_I),
		.core_oe_i(CORE_OE_I),
		.pad_in_i(PAD_IN_I),
		.pad_out_o(PAD_OUT_O),
		.pad_oe_o(PAD_OE_O)
	);
endmodule : bstd_tap

// ### bench/bstd_tap_asserts.sv
// Checker for the scan port timing of the tap decoder top.
// Assumes it is bound to bstd_tap and sees only its ports.
`timescale 1ns/1ps
module bstd_tap_asserts
	import bstd_pkg::*;
#(
	parameter int NPINS = 8
) (
	// Clocks and reset.
	input wire logic CORE_CLK_I,
	input wire logic RESET_N_I,
	input wire logic TCK_I,
	// Scan link.
	input wire logic TMS_I,
	input wire logic TDO_O,
	input wire logic TDO_OE_O,
	// User pins.
	input wire logic [NPINS-1:0] PAD_OE_O
);
	logic tdo_neg_r; // Serial output as seen just before the last rising edge.
	logic oe_neg_r;  // Output enable as seen just before the last rising edge.

	// Records both outputs at every rising test clock edge; they must then hold until the
	// next falling edge, so a change launched by the rising edge shows up as a difference.
	always_ff @(posedge TCK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tdo_neg_r <= 1'b0;
			oe_neg_r <= 1'b0;
		end else begin
			tdo_neg_r <= TDO_O;
			oe_neg_r <= TDO_OE_O;
		end
	end

	tdo_edge_a: assert property (@(negedge TCK_I) disable iff (!RESET_N_I)
		TDO_O == tdo_neg_r) else $error("Serial output moved away from a falling edge.");
	oe_edge_a: assert property (@(negedge TCK_I) disable iff (!RESET_N_I)
		TDO_OE_O == oe_neg_r) else $error("Output enable moved away from a falling edge.");
	core_reset_a: assert property (@(posedge CORE_CLK_I)
		!RESET_N_I |-> (PAD_OE_O == '0 && !TDO_OE_O && !TDO_O)) else $error("Outputs active in reset.");
	oe_rise_a: assert property (@(posedge TCK_I) disable iff (!RESET_N_I)
		$rose(TDO_OE_O) |-> !$past(TMS_I)) else $error("Shift entered without mode low.");
	oe_fall_a: assert property (@(posedge TCK_I) disable iff (!RESET_N_I)
		$fell(TDO_OE_O) |-> $past(TMS_I)) else $error("Shift left without mode high.");
	oe_hold_a: assert property (@(posedge TCK_I) disable iff (!RESET_N_I)
		TDO_OE_O && !TMS_I |=> TDO_OE_O) else $error("Shift state dropped early.");
	oe_leave_a: assert property (@(posedge TCK_I) disable iff (!RESET_N_I)
		TDO_OE_O && TMS_I |=> !TDO_OE_O) else $error("Output still driven after shift.");
	tap_reset_a: assert property (@(posedge TCK_I) disable iff (!RESET_N_I)
		TMS_I [*5] |=> !TDO_OE_O) else $error("Five mode-high clocks did not reset.");
endmodule : bstd_tap_asserts

bind bstd_tap bstd_tap_asserts #(.NPINS(NPINS)) u_chk (.CORE_CLK_I(CORE_CLK_I),
	.RESET_N_I(RESET_N_I), .TCK_I(TCK_I), .TMS_I(TMS_I), .TDO_O(TDO_O),
	.TDO_OE_O(TDO_OE_O), .PAD_OE_O(PAD_OE_O));

// ### bench/bstd_tester.sv
// Model of the external scan controller that drives the test clock.
// Assumes the caller starts scans from the idle state; the clock rests low between frames.
`timescale 1ns/1ps
module bstd_tester #(
	parameter int CFG_WAIT_NS = 2000
) (
	output logic tck_o,
	output logic tms_o,
	output logic tdi_o,
	input wire logic tdo_i
);
	// The clock stands still low until a frame starts.
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// Waits out power-up and configuration before any scan.
	task wait_ready();
		#CFG_WAIT_NS;
	endtask : wait_ready

	// One 80 ns test clock; the output is taken at the rising edge.
	task tick(input logic tms_v, input logic tdi_v, output logic tdo_v);
		tms_o = tms_v;
		tdi_o = tdi_v;
		#40;
		tck_o = 1'b1;
		tdo_v = tdo_i;
		#40;
		tck_o = 1'b0;
	endtask : tick

	// Five mode-high clocks, then back to idle.
	task reset_tap();
		logic d;
		repeat (5) tick(1'b1, 1'b0, d);
		tick(1'b0, 1'b0, d);
	endtask : reset_tap

	// Full instruction or data scan from idle back to idle, least significant bit first.
	task scan(input logic is_ir, input int n, input logic [63:0] din, output logic [63:0] dout);
		logic d;
		int i;
		dout = '0;
		tick(1'b1, 1'b0, d);
		if (is_ir) tick(1'b1, 1'b0, d);
		tick(1'b0, 1'b0, d);
		tick(1'b0, 1'b0, d);
		for (i = 0; i < n; i++) begin
			tick(i == n - 1, din[i], d);
			dout[i] = d;
		end
		tick(1'b1, 1'b0, d);
		tick(1'b0, 1'b0, d);
	endtask : scan
endmodule : bstd_tester

// ### bench/test_boundary_scan_tap_decoder.sv
// Self-checking bench for the tap decoder: instruction table, scan paths, pins.
// Assumes default user and identification values on the design.
`timescale 1ns/1ps
module test_boundary_scan_tap_decoder;
	import bstd_pkg::*;
	localparam int NP = 8;       // Number of user pins.
	localparam int LIMIT = 20000; // Core cycles before the run is declared hung.
	logic CORE_CLK_I, RESET_N_I, clk_en, tck, tms, tdi, tdo, tdo_oe, d;
	logic [NP-1:0] core_out, core_oe, pad_in, pad_out, pad_oe;
	logic [63:0] din, dout;
	logic [9:0] codes [8];
	int num_errors = 0;
	int n_compared = 0;
	int cycles = 0;

	bstd_tap #(.NPINS(NP)) dut (.CORE_CLK_I(CORE_CLK_I), .RESET_N_I(RESET_N_I),
		.CLK_EN_I(clk_en), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi), .TDO_O(tdo),
		.TDO_OE_O(tdo_oe), .CORE_OUT_I(core_out), .CORE_OE_I(core_oe),
		.PAD_IN_I(pad_in), .PAD_OUT_O(pad_out), .PAD_OE_O(pad_oe));
	bstd_tester tester (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));

	// Core clock, 20 ns period.
	initial begin
		CORE_CLK_I = 1'b0;
		forever #10 CORE_CLK_I = ~CORE_CLK_I;
	end

	// Prints the verdict and ends the run.
	task finish_test();
		if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test

	// Compares one value and reports a difference.
	task check(input string what, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// Expected 64-bit shift-out of the data path chosen by an instruction.
	function automatic logic [63:0] exp_dr(input logic [9:0] ir, input logic [63:0] di,
		input logic [NP-1:0] pins);
		case (ir)
			IR_USERCODE: return {di[31:0], USERCODE_RST};
			IR_IDCODE: return {di[31:0], IDCODE_DEF};
			IR_SAMPLE, IR_EXTEST: return {di[63-NP:0], pins};
			default: return {di[62:0], 1'b0};
		endcase
	endfunction : exp_dr

	// Cuts a hung run short.
	always @(posedge CORE_CLK_I) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			num_errors++;
			finish_test();
		end
	end

	// Main sequence: reset, identification, then every instruction code.
	initial begin
		RESET_N_I = 1'b0;
		clk_en = 1'b1;
		core_out = '0;
		core_oe = '0;
		pad_in = '0;
		void'($urandom(54));
		codes = '{IR_SAMPLE, IR_EXTEST, IR_BYPASS, IR_USERCODE, IR_IDCODE, IR_HIGHZ,
			10'h000, {1'b1, 9'($urandom)}};
		tester.tick(1'b1, 1'b0, d);
		repeat (16) @(posedge CORE_CLK_I);
		RESET_N_I <= 1'b1;
		tester.wait_ready();
		tester.tick(1'b0, 1'b0, d);
		din = {$urandom, $urandom};
		tester.scan(1'b0, 64, din, dout);
		check("idcode after reset", exp_dr(IR_IDCODE, din, '0), dout);
		for (int k = 0; k < 8; k++) begin
			@(posedge CORE_CLK_I);
			pad_in <= NP'($urandom);
			core_out <= NP'($urandom);
			core_oe <= NP'($urandom);
			din = {$urandom, $urandom};
			tester.scan(1'b1, 10, {54'h0, codes[k]}, dout);
			check("ir capture", IR_CAPTURE, dout[9:0]);
			tester.scan(1'b0, 64, din, dout);
			check("dr path", exp_dr(codes[k], din, pad_in), dout);
			repeat (6) @(posedge CORE_CLK_I);
			if (codes[k] == IR_EXTEST) begin
				check("extest pad out", din[63:64-NP], pad_out);
				check("extest pad oe", {NP{1'b1}}, pad_oe);
			end else if (codes[k] == IR_HIGHZ) begin
				check("highz pad oe", '0, pad_oe);
			end else begin
				check("core pad out", core_out, pad_out);
				check("core pad oe", core_oe, pad_oe);
			end
		end
		// Clock enable low must freeze the pin block although the core data moves.
		@(posedge CORE_CLK_I);
		din[NP-1:0] = pad_out;
		clk_en <= 1'b0;
		core_out <= ~pad_out;
		repeat (6) @(posedge CORE_CLK_I);
		check("frozen pad out", din[NP-1:0], pad_out);
		clk_en <= 1'b1;
		repeat (6) @(posedge CORE_CLK_I);
		check("released pad out", core_out, pad_out);
		tester.reset_tap();
		din = {$urandom, $urandom};
		tester.scan(1'b0, 64, din, dout);
		check("idcode after tap reset", exp_dr(IR_IDCODE, din, '0), dout);
		finish_test();
	end
endmodule : test_boundary_scan_tap_decoder
